// file: hdl/synth_divider_power_regs.sv
// divider and power-down register bank of a dual frequency synthesizer
`default_nettype none
module synth_divider_power_regs
    import synth_regs_pkg::*;
(
    // clock and reset
    input wire logic clock_i,
    input wire logic sys_rst_i,
    // assembled serial words
    input wire logic word_valid_i,
    input wire logic [WORD_W-1:0] word_data_i,
    // power control
    input wire logic chip_enable_i,
    input wire logic auto_powerup_i,
    // divider input ticks
    input wire logic main_vco_tick_i,
    input wire logic aux_vco_tick_i,
    // main loop fields
    output logic main_loop_powerdown_o,
    output logic main_prescaler_select_o,
    output logic [MAIN_REF_W-1:0] main_ref_divider_o,
    output logic [MAIN_FDEN_W-1:0] main_frac_denominator_o,
    output logic [MAIN_N_W-1:0] main_feedback_divide_o,
    // aux loop fields
    output logic aux_loop_powerdown_o,
    output logic [AUX_N_W-1:0] aux_feedback_divide_o,
    // power state
    output logic main_loop_powered_o,
    output logic main_cp_float_o,
    output logic aux_loop_powered_o,
    output logic aux_cp_float_o,
    // divider outputs
    output logic main_fb_pulse_o,
    output logic aux_fb_pulse_o
);
    // -------------------------------------------------------------
    // decode
    // -------------------------------------------------------------
    function automatic logic sel_is(input logic [WORD_W-1:0] w, input logic [SEL_W-1:0] code);
        sel_is = (w[SEL_LSB +: SEL_W] == code);
    endfunction : sel_is

    wire write_main = word_valid_i && sel_is(word_data_i, SEL_MAIN_CFG);
    wire write_aux = word_valid_i && sel_is(word_data_i, SEL_AUX_CFG);
    wire write_nword = word_valid_i && !word_data_i[NWORD_FLAG_POS];

    // -------------------------------------------------------------
    // chip enable synchroniser
    // -------------------------------------------------------------
    logic ce_meta_reg;
    logic ce_sync_reg;

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            ce_meta_reg <= 1'b0;
            ce_sync_reg <= 1'b0;
        end else begin
            ce_meta_reg <= chip_enable_i;
            ce_sync_reg <= ce_meta_reg;
        end
    end

    // -------------------------------------------------------------
    // main-loop configuration register
    // -------------------------------------------------------------
    logic main_pd_reg;
    logic main_psel_reg;
    logic [MAIN_REF_W-1:0] main_ref_reg;
    logic [MAIN_FDEN_W-1:0] main_fden_reg;

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            main_pd_reg <= RST_MAIN_PD;
            main_psel_reg <= RST_MAIN_PSEL;
            main_ref_reg <= RST_MAIN_REF;
            main_fden_reg <= RST_MAIN_FDEN;
        end else if (write_main) begin
            main_pd_reg <= word_data_i[MAIN_PD_POS];
            main_psel_reg <= word_data_i[MAIN_PSEL_POS];
            main_ref_reg <= word_data_i[MAIN_REF_LSB +: MAIN_REF_W];
            main_fden_reg <= word_data_i[MAIN_FDEN_LSB +: MAIN_FDEN_W];
        end
    end

    // -------------------------------------------------------------
    // auxiliary configuration register
    // -------------------------------------------------------------
    logic aux_pd_reg;
    logic aux_pd_next;
    logic [AUX_N_W-1:0] aux_n_reg;

    always_comb begin
        aux_pd_next = aux_pd_reg;
        if (write_aux) begin
            aux_pd_next = word_data_i[AUX_PD_POS];
        end else if (write_nword && auto_powerup_i) begin
            aux_pd_next = 1'b0;
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            aux_pd_reg <= RST_AUX_PD;
            aux_n_reg <= RST_AUX_N;
        end else begin
            aux_pd_reg <= aux_pd_next;
            if (write_aux) begin
                aux_n_reg <= word_data_i[AUX_N_LSB +: AUX_N_W];
            end
        end
    end

    // -------------------------------------------------------------
    // n-value capture and auto powerup hold
    // -------------------------------------------------------------
    logic [MAIN_N_W-1:0] main_n_reg;
    logic auto_up_hold_reg;

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            main_n_reg <= RST_MAIN_N;
        end else if (write_nword) begin
            main_n_reg <= word_data_i[MAIN_N_LSB +: MAIN_N_W];
        end
    end

    // auto powerup holds the loop up until software rewrites the main word or auto_powerup_i goes low
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            auto_up_hold_reg <= 1'b0;
        end else if (!auto_powerup_i) begin
            auto_up_hold_reg <= 1'b0;
        end else if (write_nword) begin
            auto_up_hold_reg <= 1'b1;
        end else if (write_main) begin
            auto_up_hold_reg <= 1'b0;
        end
    end

    // -------------------------------------------------------------
    // power precedence
    // -------------------------------------------------------------
    wire main_up_next = ce_sync_reg && (auto_up_hold_reg || !main_pd_reg);
    wire aux_up_next = ce_sync_reg && !aux_pd_reg;

    logic main_up_reg;
    logic aux_up_reg;
    logic main_float_reg;
    logic aux_float_reg;

    // charge pump float flags kept in their own flops so outputs stay registered
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            main_up_reg <= 1'b0;
            aux_up_reg <= 1'b0;
            main_float_reg <= 1'b1;
            aux_float_reg <= 1'b1;
        end else begin
            main_up_reg <= main_up_next;
            aux_up_reg <= aux_up_next;
            main_float_reg <= !main_up_next;
            aux_float_reg <= !aux_up_next;
        end
    end

    // -------------------------------------------------------------
    // main feedback divide split
    // -------------------------------------------------------------
    logic [COARSE_W-1:0] main_coarse_count;
    logic [SWALLOW_B_W-1:0] main_swallow_b;
    logic [SWALLOW_A_W-1:0] main_swallow_a;

    assign main_swallow_a = main_n_reg[1:0];
    assign main_swallow_b = main_psel_reg ? main_n_reg[4:2] : {1'b0, main_n_reg[3:2]};
    assign main_coarse_count = main_psel_reg ? {10'h000, main_n_reg[10:5]} : {10'h000, main_n_reg[9:4]};

    wire [BASE_W-1:0] main_base = main_psel_reg ? MAIN_BASE_LARGE : MAIN_BASE_SMALL;

    // aux: 8/9 prescaler, low 3 bits swallowed one at a time
    wire [COARSE_W-1:0] aux_coarse = aux_n_reg[AUX_N_W-1:AUX_A_W];
    wire [AUX_A_W-1:0] aux_swallow = aux_n_reg[AUX_A_W-1:0];

    logic main_pulse;
    logic aux_pulse;

    swallow_divider main_div (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .run_i(main_up_reg),
        .tick_i(main_vco_tick_i),
        .base_i(main_base),
        .coarse_i(main_coarse_count),
        .swallow_b_i(main_swallow_b),
        .swallow_a_i({1'b0, main_swallow_a}),
        .pulse_o(main_pulse)
    );

    swallow_divider aux_div (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .run_i(aux_up_reg),
        .tick_i(aux_vco_tick_i),
        .base_i(AUX_BASE),
        .coarse_i(aux_coarse),
        .swallow_b_i(3'd0),
        .swallow_a_i(aux_swallow),
        .pulse_o(aux_pulse)
    );

    // -------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------
    assign main_loop_powerdown_o = main_pd_reg;
    assign main_prescaler_select_o = main_psel_reg;
    assign main_ref_divider_o = main_ref_reg;
    assign main_frac_denominator_o = main_fden_reg;
    assign main_feedback_divide_o = main_n_reg;
    assign aux_loop_powerdown_o = aux_pd_reg;
    assign aux_feedback_divide_o = aux_n_reg;
    assign main_loop_powered_o = main_up_reg;
    assign main_cp_float_o = main_float_reg;
    assign aux_loop_powered_o = aux_up_reg;
    assign aux_cp_float_o = aux_float_reg;
    assign main_fb_pulse_o = main_pulse;
    assign aux_fb_pulse_o = aux_pulse;
endmodule : synth_divider_power_regs
`default_nettype wire

// file: shared/synth_regs_pkg.sv
// constants for the synthesizer divider and power-down register bank
`default_nettype none
package synth_regs_pkg;
    // -------------------------------------------------------------
    // word layout
    // -------------------------------------------------------------
    localparam int WORD_W = 24;
    localparam int SEL_W = 4;
    localparam logic [SEL_W-1:0] SEL_MAIN_CFG = 4'h3;
    localparam logic [SEL_W-1:0] SEL_AUX_CFG = 4'h5;
    localparam int SEL_LSB = 0;
    localparam int NWORD_FLAG_POS = 0;

    // main-loop configuration word
    localparam int MAIN_PD_POS = 23;
    localparam int MAIN_PSEL_POS = 22;
    localparam int MAIN_REF_LSB = 16;
    localparam int MAIN_REF_W = 6;
    localparam int MAIN_FDEN_LSB = 4;
    localparam int MAIN_FDEN_W = 12;

    // auxiliary configuration word
    localparam int AUX_PD_POS = 23;
    localparam int AUX_N_LSB = 4;
    localparam int AUX_N_W = 19;
    localparam int AUX_A_W = 3;

    // n-value word
    localparam int MAIN_N_LSB = 13;
    localparam int MAIN_N_W = 11;
    localparam int SWALLOW_A_W = 2;
    localparam int SWALLOW_B_W = 3;
    localparam int COARSE_W = 16;

    // -------------------------------------------------------------
    // prescaler bases and reset values
    // -------------------------------------------------------------
    localparam int BASE_W = 6;
    localparam logic [BASE_W-1:0] MAIN_BASE_SMALL = 6'h10;
    localparam logic [BASE_W-1:0] MAIN_BASE_LARGE = 6'h20;
    localparam logic [BASE_W-1:0] AUX_BASE = 6'h08;

    localparam logic RST_MAIN_PD = 1'b1;
    localparam logic RST_MAIN_PSEL = 1'b0;
    localparam logic [MAIN_REF_W-1:0] RST_MAIN_REF = 6'h01;
    localparam logic [MAIN_FDEN_W-1:0] RST_MAIN_FDEN = 12'h000;
    localparam logic RST_AUX_PD = 1'b1;
    localparam logic [AUX_N_W-1:0] RST_AUX_N = 19'h0_0038;
    localparam logic [MAIN_N_W-1:0] RST_MAIN_N = 11'h0E7;
endpackage : synth_regs_pkg
`default_nettype wire

// file: hdl/swallow_divider.sv
// swallow-counter feedback divider: total = base*coarse + 4*b + a
`default_nettype none
module swallow_divider
    import synth_regs_pkg::*;
(
    // clock and reset
    input wire logic clock_i,
    input wire logic sys_rst_i,
    // control
    input wire logic run_i,
    input wire logic tick_i,
    input wire logic [BASE_W-1:0] base_i,
    input wire logic [COARSE_W-1:0] coarse_i,
    input wire logic [SWALLOW_B_W-1:0] swallow_b_i,
    input wire logic [AUX_A_W-1:0] swallow_a_i,
    // result
    output logic pulse_o
);
    logic [BASE_W:0] pre_reg;
    logic [COARSE_W-1:0] coarse_reg;
    logic [SWALLOW_B_W-1:0] b_reg;
    logic [AUX_A_W-1:0] a_reg;
    logic pulse_reg;

    wire [BASE_W:0] modulus = {1'b0, base_i} + ((b_reg != '0) ? 7'd4 : 7'd0) + ((a_reg != '0) ? 7'd1 : 7'd0);
    wire cycle_end = tick_i && (pre_reg == modulus - 7'd1);
    wire last_cycle = (coarse_reg <= 16'h0001);
    wire wrap = cycle_end && last_cycle;

    // prescaler cycles swallow +4 while b left, +1 while a left
    always_ff @(posedge clock_i) begin
        if (sys_rst_i || !run_i || wrap) begin
            pre_reg <= '0;
            coarse_reg <= coarse_i;
            b_reg <= swallow_b_i;
            a_reg <= swallow_a_i;
        end else if (cycle_end) begin
            pre_reg <= '0;
            coarse_reg <= coarse_reg - 16'h0001;
            b_reg <= (b_reg != '0) ? b_reg - 3'd1 : b_reg;
            a_reg <= (a_reg != '0) ? a_reg - 3'd1 : a_reg;
        end else if (tick_i) begin
            pre_reg <= pre_reg + 7'd1;
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            pulse_reg <= 1'b0;
        end else begin
            pulse_reg <= run_i && wrap;
        end
    end

    assign pulse_o = pulse_reg;
endmodule : swallow_divider
`default_nettype wire

// file: bench/host_model.sv
// host side model that hands complete words to the register bank
`default_nettype none
module host_model
    import synth_regs_pkg::*;
(
    // clock and word out
    input wire logic clock_i,
    output logic word_valid_o,
    output logic [WORD_W-1:0] word_data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        word_valid_o = 1'b0;
        word_data_o = '0;
    end
    // idle data is the inverse of the last word; callers pick legal divides
    task automatic send(input logic [WORD_W-1:0] w);
        word_valid_o <= 1'b1;
        word_data_o <= w;
        @(posedge clock_i);
        word_valid_o <= 1'b0;
        word_data_o <= ~w;
    endtask : send
endmodule : host_model
`default_nettype wire

// file: bench/synth_regs_chk.sv
// assertion checker for the synthesizer register bank
`default_nettype none
module synth_regs_chk
    import synth_regs_pkg::*;
(
    // clock, words, power control
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic word_valid_i,
    input wire logic [WORD_W-1:0] word_data_i,
    input wire logic chip_enable_i,
    input wire logic auto_powerup_i,
    // observed outputs
    input wire logic main_loop_powerdown_o,
    input wire logic main_prescaler_select_o,
    input wire logic [MAIN_REF_W-1:0] main_ref_divider_o,
    input wire logic [MAIN_FDEN_W-1:0] main_frac_denominator_o,
    input wire logic [MAIN_N_W-1:0] main_feedback_divide_o,
    input wire logic aux_loop_powerdown_o,
    input wire logic [AUX_N_W-1:0] aux_feedback_divide_o,
    input wire logic main_loop_powered_o,
    input wire logic main_cp_float_o,
    input wire logic aux_loop_powered_o,
    input wire logic aux_cp_float_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] ce_cnt;
    wire logic ce_ok = ce_cnt >= 3'h4;
    wire logic main_wr = word_valid_i && word_data_i[3:0] == SEL_MAIN_CFG;
    wire logic aux_wr = word_valid_i && word_data_i[3:0] == SEL_AUX_CFG;
    wire logic n_wr = word_valid_i && !word_data_i[0];
    // consecutive cycles with chip enable high
    always_ff @(posedge clock_i) begin
        if (sys_rst_i || !chip_enable_i) ce_cnt <= 3'h0;
        else if (ce_cnt != 3'h7) ce_cnt <= ce_cnt + 3'h1;
    end
    default clocking @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);
    a_main_fields: assert property (main_wr |=> {main_loop_powerdown_o, main_prescaler_select_o,
        main_ref_divider_o, main_frac_denominator_o} == $past(word_data_i[23:4])) else $error("main word");
    a_aux_fields: assert property (aux_wr |=>
        {aux_loop_powerdown_o, aux_feedback_divide_o} == $past(word_data_i[23:4])) else $error("aux word");
    a_main_n: assert property (n_wr |=>
        main_feedback_divide_o == $past(word_data_i[23:13])) else $error("n value");
    a_ce_low_off: assert property (!chip_enable_i [*3] |=>
        !main_loop_powered_o && !aux_loop_powered_o) else $error("ce low");
    a_sw_main_on: assert property (ce_ok && $past(!main_loop_powerdown_o) |-> main_loop_powered_o)
        else $error("main not on");
    a_sw_main_off: assert property ($past(!auto_powerup_i, 2) && $past(main_loop_powerdown_o)
        |-> !main_loop_powered_o) else $error("main not off");
    a_auto_main_up: assert property (n_wr && auto_powerup_i && ce_ok |-> ##2 main_loop_powered_o)
        else $error("autopowerup main");
    a_auto_aux_clr: assert property (n_wr && auto_powerup_i |=> !aux_loop_powerdown_o)
        else $error("autopowerup aux");
    a_aux_power_bit: assert property (ce_ok |-> aux_loop_powered_o == !$past(aux_loop_powerdown_o))
        else $error("aux power");
    a_cp_float_inv: assert property (main_cp_float_o == !main_loop_powered_o &&
        aux_cp_float_o == !aux_loop_powered_o) else $error("charge pump float");
    c_main_wr: cover property (main_wr);
    c_auto_wr: cover property (n_wr && auto_powerup_i);
    c_both_on: cover property (main_loop_powered_o && aux_loop_powered_o);
endmodule : synth_regs_chk
bind synth_divider_power_regs synth_regs_chk i_chk (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .word_valid_i(word_valid_i), .word_data_i(word_data_i), .chip_enable_i(chip_enable_i),
    .auto_powerup_i(auto_powerup_i), .main_loop_powerdown_o(main_loop_powerdown_o),
    .main_prescaler_select_o(main_prescaler_select_o), .main_ref_divider_o(main_ref_divider_o),
    .main_frac_denominator_o(main_frac_denominator_o), .main_feedback_divide_o(main_feedback_divide_o),
    .aux_loop_powerdown_o(aux_loop_powerdown_o), .aux_feedback_divide_o(aux_feedback_divide_o),
    .main_loop_powered_o(main_loop_powered_o), .main_cp_float_o(main_cp_float_o),
    .aux_loop_powered_o(aux_loop_powered_o), .aux_cp_float_o(aux_cp_float_o));
`default_nettype wire

// file: bench/testbench.sv
// self-checking testbench for the synthesizer register bank
`default_nettype none
module testbench
    import synth_regs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_i, sys_rst_i, chip_enable_i, auto_powerup_i, mt, at, mp, ap, took, word_valid_i;
    logic [WORD_W-1:0] word_data_i, w;
    logic [50:0] fields, m;
    logic [50:0] q[$];
    logic [3:0] pw;
    logic [10:0] nv;
    int error_cnt = 0, cmp_count = 0, cyc = 0, n;
    host_model h (.clock_i(clock_i), .word_valid_o(word_valid_i), .word_data_o(word_data_i));
    synth_divider_power_regs i_dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .word_valid_i(word_valid_i),
        .word_data_i(word_data_i), .chip_enable_i(chip_enable_i), .auto_powerup_i(auto_powerup_i),
        .main_vco_tick_i(mt), .aux_vco_tick_i(at), .main_loop_powerdown_o(fields[50]),
        .main_prescaler_select_o(fields[49]), .main_ref_divider_o(fields[48:43]),
        .main_frac_denominator_o(fields[42:31]), .main_feedback_divide_o(fields[30:20]),
        .aux_loop_powerdown_o(fields[19]), .aux_feedback_divide_o(fields[18:0]), .main_loop_powered_o(pw[0]),
        .main_cp_float_o(pw[1]), .aux_loop_powered_o(pw[2]), .aux_cp_float_o(pw[3]),
        .main_fb_pulse_o(mp), .aux_fb_pulse_o(ap));
    initial begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end
    task automatic check(input logic [50:0] seen, input logic [50:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : give_verdict
    // note expected fields, then send the word
    task automatic put(input logic [WORD_W-1:0] wd);
        if (wd[3:0] == SEL_MAIN_CFG) m[50:31] = wd[23:4];
        if (wd[3:0] == SEL_AUX_CFG) m[19:0] = wd[23:4];
        if (!wd[0]) m[30:20] = wd[23:13];
        if (!wd[0] && auto_powerup_i) m[19] = 1'b0;
        q.push_back(m);
        h.send(wd);
        @(posedge clock_i);
    endtask : put
    // cycles between two feedback pulses, after one pulse to flush old settings
    task automatic gap(input logic sel, output int cnt);
        int k;
        k = 0;
        cnt = 0;
        while (k < 2 && cnt < 5000) begin
            @(negedge clock_i);
            cnt++;
            if (sel ? mp : ap) begin
                k++;
                if (k == 1) cnt = 0;
            end
        end
        @(posedge clock_i);
    endtask : gap
    always @(negedge clock_i) begin
        if (took) check(fields, q.pop_front());
        took = word_valid_i;
    end
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 40000) begin
            error_cnt++;
            give_verdict();
        end
    end
    initial begin
        void'($urandom(32'h0000_dc34));
        {sys_rst_i, chip_enable_i, auto_powerup_i, mt, at, took} = 6'b10_0000;
        m = {RST_MAIN_PD, RST_MAIN_PSEL, RST_MAIN_REF, RST_MAIN_FDEN, RST_MAIN_N, RST_AUX_PD, RST_AUX_N};
        repeat (12) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        @(negedge clock_i);
        check(fields, m);
        check(pw, 4'b1010);
        $display("reset test done");
        @(posedge clock_i);
        chip_enable_i <= 1'b1;
        // every odd select code, random fields, legal ref and aux values
        for (int i = 0; i < 16; i++) begin
            put({2'b00, 6'($urandom_range(63, 1)), 12'($urandom), 4'(2 * (i % 8) + 1)});
        end
        repeat (4) @(posedge clock_i);
        @(negedge clock_i);
        check(pw, 4'b0101);
        @(posedge clock_i);
        put({1'b1, 1'b1, 6'h01, 12'h000, SEL_MAIN_CFG});
        put({1'b1, 19'h0_0039, SEL_AUX_CFG});
        repeat (2) @(posedge clock_i);
        @(negedge clock_i);
        check(pw, 4'b1010);
        $display("field and power bit test done");
        @(posedge clock_i);
        auto_powerup_i <= 1'b1;
        @(posedge clock_i);
        nv = 11'($urandom_range(2039, 231));
        put({nv, 12'($urandom), 1'b0});
        repeat (2) @(posedge clock_i);
        @(negedge clock_i);
        check(pw, 4'b0101);
        @(posedge clock_i);
        mt <= 1'b1;
        at <= 1'b1;
        gap(1'b1, n);
        check(n, nv);
        gap(1'b0, n);
        check(n, 57);
        put({1'b0, 1'b0, 6'h01, 12'h000, SEL_MAIN_CFG});
        nv = 11'($urandom_range(1023, 80));
        put({nv, 12'h000, 1'b0});
        gap(1'b1, n);
        check(n, nv);
        $display("autopowerup and divider test done");
        chip_enable_i <= 1'b0;
        put({nv, 12'h000, 1'b0});
        repeat (4) @(posedge clock_i);
        @(negedge clock_i);
        check(pw, 4'b1010);
        $display("chip enable test done");
        give_verdict();
    end
endmodule : testbench
`default_nettype wire
